// ---- inc/mrr_defines.svh ----
// register indices, field positions, reset values and timing counts of the meter result bank
// assumes a 4 ns system clock and that the compute engine runs on that clock
//
// How it works
// - squared current sums per phase from engine, zeroed under creep
// - per-phase current residue difference, this minus previous
// - neutral residue difference, scaled by two to -10
// - accumulate squared sum of three currents
// - three 9-bit load angles packed A,B,C, A highest
// - load angle one degree, positive means lagging
// - engine-only mode blanks post-processed results
// - rms results only in upper sixteen bits
// - A-to-C angle low, A-to-B angle high
// - selected line frequency in upper half-word
// - count zero crossings of selected phase
// - real, reactive, apparent energy of last interval
// - creep threshold zeroes squared current, real and reactive energy
// - sag alarm after dwell count samples low
// - dwell count range 1..32767, defaults to 80
// - one dwell count equals one 397 us sample
// - squared voltage sums per phase, straight from engine
// - peak must beat threshold every dwell window
`ifndef MRR_DEFINES_SVH
`define MRR_DEFINES_SVH

// ----------------------------------------
// register indices
// ----------------------------------------
`define MRR_REAL_ENERGY_A 7'h00
`define MRR_REAL_ENERGY_B 7'h01
`define MRR_REAL_ENERGY_C 7'h02
`define MRR_REACTIVE_ENERGY_A 7'h03
`define MRR_REACTIVE_ENERGY_B 7'h04
`define MRR_REACTIVE_ENERGY_C 7'h05
`define MRR_APPARENT_ENERGY_A 7'h06
`define MRR_APPARENT_ENERGY_B 7'h07
`define MRR_APPARENT_ENERGY_C 7'h08
`define MRR_RMS_VOLTAGE_A 7'h09
`define MRR_RMS_VOLTAGE_B 7'h0A
`define MRR_RMS_VOLTAGE_C 7'h0B
`define MRR_RMS_CURRENT_A 7'h0C
`define MRR_RMS_CURRENT_B 7'h0D
`define MRR_RMS_CURRENT_C 7'h0E
`define MRR_LOAD_ANGLE_ALL_PHASES 7'h0F
`define MRR_LINE_TO_LINE_ANGLES 7'h10
`define MRR_LINE_FREQ_AND_TEMP_OFFSET 7'h11
`define MRR_NO_LOAD_THRESHOLD 7'h1D
`define MRR_VOLTAGE_DIP_CONFIG 7'h2E
`define MRR_ZERO_CROSSING_COUNT 7'h35
`define MRR_SQUARED_CURRENT_SUM_A 7'h39
`define MRR_SQUARED_CURRENT_SUM_B 7'h3A
`define MRR_SQUARED_CURRENT_SUM_C 7'h3B
`define MRR_SQUARED_NEUTRAL_SUM 7'h3C
`define MRR_SQUARED_VOLTAGE_SUM_A 7'h3D
`define MRR_SQUARED_VOLTAGE_SUM_B 7'h3E
`define MRR_SQUARED_VOLTAGE_SUM_C 7'h3F
`define MRR_SQUARED_CURRENT_RESIDUE_A 7'h4A
`define MRR_SQUARED_CURRENT_RESIDUE_B 7'h4B
`define MRR_SQUARED_CURRENT_RESIDUE_C 7'h4C
`define MRR_SQUARED_NEUTRAL_RESIDUE 7'h4D

// ----------------------------------------
// fields and reset values
// ----------------------------------------
`define MRR_RESIDUE_BITS 10
`define MRR_DIP_COUNT_RESET 16'h0050
`define MRR_DIP_COUNT_MAX 16'h7FFF
`define MRR_THRESHOLD_RESET 32'h0000_0000

// ----------------------------------------
// timing
// ----------------------------------------
`define MRR_CLOCK_PERIOD_NS 4
`define MRR_SAMPLE_PERIOD_US 397
`define MRR_SAMPLE_CYCLES ((`MRR_SAMPLE_PERIOD_US * 1000) / `MRR_CLOCK_PERIOD_NS)

`endif

// ---- inc/mrr_pkg.sv ----
// types shared by the meter result bank
// assumes the defines header is compiled alongside
`default_nettype none

package mrr_pkg;
  typedef logic [31:0] mrr_word_t;
  typedef logic [6:0] mrr_index_t;
  typedef logic [15:0] mrr_half_t;
endpackage

`default_nettype wire

// ---- core/mrr_result_regs.sv ----
// meter result register bank: latches per-interval engine results, computes
// neutral sums, residue differences, zero crossings and sag dwell
// assumes engine inputs are synchronous to clock and held stable with their strobes
`include "mrr_defines.svh"
`default_nettype none

module mrr_result_regs #(
  parameter int SAMPLE_CYCLES = `MRR_SAMPLE_CYCLES
) (
  // clock, reset, enable
  input wire logic clock,
  input wire logic rst_b,
  input wire logic ce,
  // host register port
  input wire mrr_pkg::mrr_index_t reg_index,
  input wire logic reg_rd,
  input wire logic reg_wr,
  input wire mrr_pkg::mrr_word_t reg_wdata,
  output mrr_pkg::mrr_word_t reg_rdata,
  output logic reg_rvalid,
  output logic write_ignored,
  // configuration
  input wire logic engine_only,
  input wire logic [1:0] freq_select,
  // engine interval results
  input wire logic interval_end,
  input wire logic [2:0][31:0] real_in,
  input wire logic [2:0][31:0] reactive_in,
  input wire logic [2:0][31:0] apparent_in,
  input wire logic [2:0][15:0] rms_volt_in,
  input wire logic [2:0][15:0] rms_cur_in,
  input wire logic [2:0][31:0] isq_sum_in,
  input wire logic [2:0][9:0] isq_residue_in,
  input wire logic [2:0][31:0] vsq_sum_in,
  input wire logic [2:0][8:0] load_angle_in,
  input wire logic [15:0] angle_a_to_c_in,
  input wire logic [15:0] angle_a_to_b_in,
  input wire logic [15:0] frequency_in,
  input wire logic [15:0] temp_offset_in,
  // engine samples
  input wire logic sample_valid,
  input wire logic [2:0][15:0] cur_sample,
  input wire logic [2:0][15:0] volt_sample,
  input wire logic [15:0] peak_volt_in,
  // alarm
  output logic sag_alarm
);

  // ----------------------------------------
  // held results
  // ----------------------------------------
  logic [2:0][31:0] real_r, reactive_r, apparent_r, isq_r, vsq_r, ifract_r;
  logic [2:0][15:0] rms_volt_r, rms_cur_r;
  logic [2:0][9:0] ires_prev_r;
  logic [2:0][8:0] angle_r;
  logic [15:0] a_to_c_r, a_to_b_r, freq_r, temp_r;
  logic [31:0] nsum_r, nfract_r, zc_count_r;
  logic [31:0] no_load_threshold_r;
  logic [31:0] dip_config_r;
  logic [41:0] nacc_r;
  logic [31:0] zc_run_r;
  logic zc_sign_r;
  logic [31:0] tick_cnt_r;
  logic [15:0] dip_run_r;
  mrr_pkg::mrr_word_t rdata_nxt;
  logic rd_hit;

  // ----------------------------------------
  // creep suppression per phase
  // ----------------------------------------
  logic [2:0] creep;
  logic [2:0][31:0] real_abs, reactive_abs;
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_creep
      assign real_abs[g] = real_in[g][31] ? 32'(-real_in[g]) : real_in[g];
      assign reactive_abs[g] = reactive_in[g][31] ? 32'(-reactive_in[g]) : reactive_in[g];
      assign creep[g] = (real_abs[g] < no_load_threshold_r) && (reactive_abs[g] < no_load_threshold_r);
    end
  endgenerate

  // ----------------------------------------
  // neutral current square
  // ----------------------------------------
  logic signed [17:0] nsum_sample;
  logic [35:0] nsq_sample;
  logic [41:0] nacc_nxt;
  logic [9:0] nres_prev_r;
  assign nsum_sample = 18'(signed'(cur_sample[0])) + 18'(signed'(cur_sample[1])) + 18'(signed'(cur_sample[2]));
  // widen before the product: a self-sized 18-bit product would drop the top of the square
  assign nsq_sample = 36'(36'(nsum_sample) * 36'(nsum_sample));
  // headroom for only about 455 full-scale samples per interval
  assign nacc_nxt = nacc_r + 42'(nsq_sample);

  // ----------------------------------------
  // zero crossings of the selected phase
  // ----------------------------------------
  logic sel_sign, zc_edge;
  assign sel_sign = (freq_select == 2'h1) ? volt_sample[1][15] :
                    (freq_select == 2'h2) ? volt_sample[2][15] : volt_sample[0][15];
  // sign bit only, so noise around zero can add crossings
  assign zc_edge = sample_valid && (sel_sign != zc_sign_r);

  // ----------------------------------------
  // sag dwell on the sample tick
  // ----------------------------------------
  logic tick;
  logic [15:0] dip_count, dip_thr, dip_run_nxt;
  assign tick = (tick_cnt_r == 32'(SAMPLE_CYCLES - 1));
  assign dip_count = dip_config_r[15:0];
  assign dip_thr = dip_config_r[31:16];
  // count 0 holds the alarm low instead of firing at once
  // saturating so a long dip does not wrap and clear the alarm
  assign dip_run_nxt = (peak_volt_in > dip_thr) ? 16'h0000 :
                       (dip_run_r == `MRR_DIP_COUNT_MAX) ? dip_run_r : 16'(dip_run_r + 16'h0001);

  // ----------------------------------------
  // host write decode
  // ----------------------------------------
  logic wr_thr, wr_dip;
  assign wr_thr = reg_wr && (reg_index == `MRR_NO_LOAD_THRESHOLD);
  assign wr_dip = reg_wr && (reg_index == `MRR_VOLTAGE_DIP_CONFIG);
  logic wr_refused;
  assign wr_refused = reg_wr && !wr_thr && !wr_dip;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      no_load_threshold_r <= `MRR_THRESHOLD_RESET;
      dip_config_r <= {16'h0000, `MRR_DIP_COUNT_RESET};
      write_ignored <= 1'b0;
    end else if (ce) begin
      if (wr_thr) begin
        no_load_threshold_r <= reg_wdata;
      end
      if (wr_dip) begin
        dip_config_r <= reg_wdata;
      end
      write_ignored <= wr_refused;
    end
  end

  // ----------------------------------------
  // interval latch: every result moves on the same edge
  // ----------------------------------------
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      real_r <= '0;
      reactive_r <= '0;
      apparent_r <= '0;
      isq_r <= '0;
      vsq_r <= '0;
      ifract_r <= '0;
      ires_prev_r <= '0;
      rms_volt_r <= '0;
      rms_cur_r <= '0;
      angle_r <= '0;
      a_to_c_r <= 16'h0000;
      a_to_b_r <= 16'h0000;
      freq_r <= 16'h0000;
      temp_r <= 16'h0000;
    end else if (ce && interval_end) begin
      for (int p = 0; p < 3; p++) begin
        real_r[p] <= creep[p] ? 32'h0000_0000 : real_in[p];
        reactive_r[p] <= creep[p] ? 32'h0000_0000 : reactive_in[p];
        apparent_r[p] <= apparent_in[p];
        isq_r[p] <= creep[p] ? 32'h0000_0000 : isq_sum_in[p];
        vsq_r[p] <= vsq_sum_in[p];
        ifract_r[p] <= 32'(signed'({1'b0, isq_residue_in[p]}) - signed'({1'b0, ires_prev_r[p]}));
        ires_prev_r[p] <= isq_residue_in[p];
        rms_volt_r[p] <= rms_volt_in[p];
        rms_cur_r[p] <= rms_cur_in[p];
        angle_r[p] <= load_angle_in[p];
      end
      a_to_c_r <= angle_a_to_c_in;
      a_to_b_r <= angle_a_to_b_in;
      freq_r <= frequency_in;
      temp_r <= temp_offset_in;
    end
  end

  // ----------------------------------------
  // neutral accumulation and zero-crossing count
  // ----------------------------------------
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      nacc_r <= '0;
      nsum_r <= 32'h0000_0000;
      nfract_r <= 32'h0000_0000;
      nres_prev_r <= 10'h000;
      zc_run_r <= 32'h0000_0000;
      zc_count_r <= 32'h0000_0000;
      zc_sign_r <= 1'b0;
    end else if (ce) begin
      if (sample_valid) begin
        zc_sign_r <= sel_sign;
      end
      if (interval_end) begin
        // a sample in the boundary cycle opens the new interval
        nacc_r <= sample_valid ? 42'(nsq_sample) : '0;
        nsum_r <= nacc_r[41:`MRR_RESIDUE_BITS];
        nfract_r <= 32'(signed'({1'b0, nacc_r[9:0]}) - signed'({1'b0, nres_prev_r}));
        nres_prev_r <= nacc_r[9:0];
        zc_count_r <= zc_run_r;
        zc_run_r <= zc_edge ? 32'h0000_0001 : 32'h0000_0000;
      end else begin
        if (sample_valid) begin
          nacc_r <= nacc_nxt;
        end
        if (zc_edge) begin
          zc_run_r <= 32'(zc_run_r + 32'h0000_0001);
        end
      end
    end
  end

  // ----------------------------------------
  // sag detection
  // ----------------------------------------
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      tick_cnt_r <= 32'h0000_0000;
      dip_run_r <= 16'h0000;
      sag_alarm <= 1'b0;
    end else if (ce) begin
      tick_cnt_r <= tick ? 32'h0000_0000 : 32'(tick_cnt_r + 32'h0000_0001);
      if (tick) begin
        dip_run_r <= dip_run_nxt;
        sag_alarm <= (dip_count != 16'h0000) && (dip_run_nxt >= dip_count);
      end
    end
  end

  // ----------------------------------------
  // post-processed results as seen by the host
  // ----------------------------------------
  // blanked on read only, so leaving engine-only mode shows the held values again
  logic [2:0][31:0] apparent_view, rms_volt_view, rms_cur_view;
  logic [31:0] angle_view;
  generate
    for (g = 0; g < 3; g++) begin : g_view
      assign apparent_view[g] = engine_only ? 32'h0000_0000 : apparent_r[g];
      assign rms_volt_view[g] = engine_only ? 32'h0000_0000 : {rms_volt_r[g], 16'h0000};
      assign rms_cur_view[g] = engine_only ? 32'h0000_0000 : {rms_cur_r[g], 16'h0000};
    end
  endgenerate
  assign angle_view = engine_only ? 32'h0000_0000 : {5'h00, angle_r[0], angle_r[1], angle_r[2]};

  // ----------------------------------------
  // read decode; reads change nothing but the read data
  // ----------------------------------------
  always_comb begin
    rdata_nxt = 32'h0000_0000;
    rd_hit = 1'b1;
    if (reg_index == `MRR_REAL_ENERGY_A) begin
      rdata_nxt = real_r[0];
    end else if (reg_index == `MRR_REAL_ENERGY_B) begin
      rdata_nxt = real_r[1];
    end else if (reg_index == `MRR_REAL_ENERGY_C) begin
      rdata_nxt = real_r[2];
    end else if (reg_index == `MRR_REACTIVE_ENERGY_A) begin
      rdata_nxt = reactive_r[0];
    end else if (reg_index == `MRR_REACTIVE_ENERGY_B) begin
      rdata_nxt = reactive_r[1];
    end else if (reg_index == `MRR_REACTIVE_ENERGY_C) begin
      rdata_nxt = reactive_r[2];
    end else if (reg_index == `MRR_APPARENT_ENERGY_A) begin
      rdata_nxt = apparent_view[0];
    end else if (reg_index == `MRR_APPARENT_ENERGY_B) begin
      rdata_nxt = apparent_view[1];
    end else if (reg_index == `MRR_APPARENT_ENERGY_C) begin
      rdata_nxt = apparent_view[2];
    end else if (reg_index == `MRR_RMS_VOLTAGE_A) begin
      rdata_nxt = rms_volt_view[0];
    end else if (reg_index == `MRR_RMS_VOLTAGE_B) begin
      rdata_nxt = rms_volt_view[1];
    end else if (reg_index == `MRR_RMS_VOLTAGE_C) begin
      rdata_nxt = rms_volt_view[2];
    end else if (reg_index == `MRR_RMS_CURRENT_A) begin
      rdata_nxt = rms_cur_view[0];
    end else if (reg_index == `MRR_RMS_CURRENT_B) begin
      rdata_nxt = rms_cur_view[1];
    end else if (reg_index == `MRR_RMS_CURRENT_C) begin
      rdata_nxt = rms_cur_view[2];
    end else if (reg_index == `MRR_LOAD_ANGLE_ALL_PHASES) begin
      rdata_nxt = angle_view;
    end else if (reg_index == `MRR_LINE_TO_LINE_ANGLES) begin
      rdata_nxt = {a_to_b_r, a_to_c_r};
    end else if (reg_index == `MRR_LINE_FREQ_AND_TEMP_OFFSET) begin
      rdata_nxt = {freq_r, temp_r};
    end else if (reg_index == `MRR_NO_LOAD_THRESHOLD) begin
      rdata_nxt = no_load_threshold_r;
    end else if (reg_index == `MRR_VOLTAGE_DIP_CONFIG) begin
      rdata_nxt = dip_config_r;
    end else if (reg_index == `MRR_ZERO_CROSSING_COUNT) begin
      rdata_nxt = zc_count_r;
    end else if (reg_index == `MRR_SQUARED_CURRENT_SUM_A) begin
      rdata_nxt = isq_r[0];
    end else if (reg_index == `MRR_SQUARED_CURRENT_SUM_B) begin
      rdata_nxt = isq_r[1];
    end else if (reg_index == `MRR_SQUARED_CURRENT_SUM_C) begin
      rdata_nxt = isq_r[2];
    end else if (reg_index == `MRR_SQUARED_NEUTRAL_SUM) begin
      rdata_nxt = nsum_r;
    end else if (reg_index == `MRR_SQUARED_VOLTAGE_SUM_A) begin
      rdata_nxt = vsq_r[0];
    end else if (reg_index == `MRR_SQUARED_VOLTAGE_SUM_B) begin
      rdata_nxt = vsq_r[1];
    end else if (reg_index == `MRR_SQUARED_VOLTAGE_SUM_C) begin
      rdata_nxt = vsq_r[2];
    end else if (reg_index == `MRR_SQUARED_CURRENT_RESIDUE_A) begin
      rdata_nxt = ifract_r[0];
    end else if (reg_index == `MRR_SQUARED_CURRENT_RESIDUE_B) begin
      rdata_nxt = ifract_r[1];
    end else if (reg_index == `MRR_SQUARED_CURRENT_RESIDUE_C) begin
      rdata_nxt = ifract_r[2];
    end else if (reg_index == `MRR_SQUARED_NEUTRAL_RESIDUE) begin
      rdata_nxt = nfract_r;
    end else begin
      rd_hit = 1'b0;
    end
  end

  // ----------------------------------------
  // read answer
  // ----------------------------------------
  // unmapped indices answer zero so a host probe is harmless
  mrr_pkg::mrr_word_t rd_word;
  assign rd_word = rd_hit ? rdata_nxt : 32'h0000_0000;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata <= 32'h0000_0000;
      reg_rvalid <= 1'b0;
    end else if (ce) begin
      reg_rvalid <= reg_rd;
      if (reg_rd) begin
        reg_rdata <= rd_word;
      end
    end
  end

endmodule // mrr_result_regs

`default_nettype wire

// ---- verification/mrr_result_regs_monitor.sv ----
// checker for the host port of the meter result bank
// assumes it is bound into mrr_result_regs, one clock domain
`default_nettype none
module mrr_result_regs_monitor (
  // clock and reset
  input wire logic clock,
  input wire logic rst_b,
  input wire logic ce,
  // host port
  input wire mrr_pkg::mrr_index_t reg_index,
  input wire logic reg_rd,
  input wire logic reg_wr,
  input wire mrr_pkg::mrr_word_t reg_wdata,
  input wire mrr_pkg::mrr_word_t reg_rdata,
  input wire logic reg_rvalid,
  input wire logic write_ignored,
  // configuration and engine
  input wire logic engine_only,
  input wire logic interval_end
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);
  wire logic rd_go = reg_rd && ce;
  wire logic wr_bad = reg_wr && ce && reg_index != 7'h1D && reg_index != 7'h2E;
  wire logic rd_rms = rd_go && reg_index >= 7'h09 && reg_index <= 7'h0E;
  wire logic rd_post = rd_go && engine_only && reg_index >= 7'h06 && reg_index <= 7'h0F;
  chk_read_answer: assert property (rd_go |=> reg_rvalid)
    else $error("read not answered");
  chk_answer_cause: assert property (reg_rvalid |-> $past(rd_go))
    else $error("answer without read");
  chk_bad_write: assert property (wr_bad |=> write_ignored)
    else $error("read-only write not flagged");
  chk_ignore_cause: assert property (write_ignored |-> $past(wr_bad))
    else $error("spurious ignore flag");
  chk_thr_roundtrip: assert property ((reg_wr && ce && reg_index == 7'h1D) ##1
    (rd_go && reg_index == 7'h1D) |=> reg_rdata == $past(reg_wdata, 2)) else $error("threshold lost");
  chk_rms_upper: assert property (rd_rms |=> reg_rdata[15:0] == 16'h0000)
    else $error("rms low half not empty");
  chk_post_blank: assert property (rd_post |=> reg_rdata == 32'h0000_0000)
    else $error("post-processed value shown in engine-only mode");
  chk_rdata_hold: assert property (!reg_rvalid |-> $stable(reg_rdata))
    else $error("read data moved without a read");
  chk_read_repeat: assert property ((rd_go && !reg_wr && !interval_end) ##1
    (rd_go && $stable(reg_index) && $stable(engine_only)) |=> $stable(reg_rdata)) else $error("read changed data");
endmodule // mrr_result_regs_monitor

bind mrr_result_regs mrr_result_regs_monitor mon (.clock(clock), .rst_b(rst_b), .ce(ce), .reg_index(reg_index),
  .reg_rd(reg_rd), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
  .write_ignored(write_ignored), .engine_only(engine_only), .interval_end(interval_end));
`default_nettype wire

// ---- verification/mrr_host_model.sv ----
// host model: one register access at a time on the index/strobe port
// assumes callers enter its tasks just after a rising clock edge
`default_nettype none
module mrr_host_model (
  // clock
  input wire logic clock,
  // register port
  output var mrr_pkg::mrr_index_t reg_index,
  output logic reg_rd,
  output logic reg_wr,
  output var mrr_pkg::mrr_word_t reg_wdata,
  input wire mrr_pkg::mrr_word_t reg_rdata,
  input wire logic reg_rvalid
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    reg_index = 7'h7F;
    reg_rd = 1'b0;
    reg_wr = 1'b0;
    reg_wdata = 32'hA5A5_A5A5;
  end
  // no wait after the strobe edge; strobe and data are released there, so a read may follow at once
  task automatic wr(input mrr_pkg::mrr_index_t idx, input mrr_pkg::mrr_word_t data);
    reg_index <= idx;
    reg_wdata <= data;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
    // released data shows the inverse so stale data never looks valid
    reg_wdata <= ~data;
  endtask
  task automatic rd(input mrr_pkg::mrr_index_t idx, output mrr_pkg::mrr_word_t data);
    reg_index <= idx;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    reg_index <= ~idx;
    @(posedge clock);
    data = reg_rvalid ? reg_rdata : 32'hXXXX_XXXX;
  endtask
  // two reads on consecutive edges; each answer is taken at the edge where it stands
  task automatic rd_pair(input mrr_pkg::mrr_index_t idx, output mrr_pkg::mrr_word_t d0,
    output mrr_pkg::mrr_word_t d1);
    reg_index <= idx;
    reg_rd <= 1'b1;
    @(posedge clock);
    @(posedge clock);
    d0 = reg_rvalid ? reg_rdata : 32'hXXXX_XXXX;
    reg_rd <= 1'b0;
    reg_index <= ~idx;
    @(posedge clock);
    d1 = reg_rvalid ? reg_rdata : 32'hXXXX_XXXX;
  endtask
endmodule // mrr_host_model
`default_nettype wire

// ---- verification/tb.sv ----
// self-checking bench for the meter result bank
// assumes the host model and the bound checker are compiled alongside
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {mrr_pkg::mrr_index_t idx; mrr_pkg::mrr_word_t exp;} mrr_row_t;
  logic clock, rst_b, ce, reg_rd, reg_wr, reg_rvalid, write_ignored, engine_only, interval_end;
  logic sample_valid, sag_alarm;
  logic [1:0] freq_select;
  mrr_pkg::mrr_index_t reg_index;
  mrr_pkg::mrr_word_t reg_wdata, reg_rdata, d, d2;
  logic [2:0][31:0] real_in, reactive_in, apparent_in, isq_sum_in, vsq_sum_in;
  logic [2:0][15:0] rms_volt_in, rms_cur_in, cur_sample, volt_sample;
  logic [2:0][9:0] isq_residue_in;
  logic [2:0][8:0] load_angle_in;
  logic [15:0] angle_a_to_c_in, angle_a_to_b_in, frequency_in, temp_offset_in, peak_volt_in;
  mrr_row_t rows[$];
  mrr_pkg::mrr_index_t cz[3] = '{7'h00, 7'h03, 7'h39};
  mrr_pkg::mrr_word_t zc[4] = '{32'h7, 32'h3, 32'h1, 32'h7};
  int miscompares = 0;
  int check_count = 0;
  int cycles = 0;
  // short sample tick keeps the dwell test brief
  mrr_result_regs #(.SAMPLE_CYCLES(4)) dut (.clock(clock), .rst_b(rst_b), .ce(ce), .reg_index(reg_index),
    .reg_rd(reg_rd), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .write_ignored(write_ignored), .engine_only(engine_only), .freq_select(freq_select),
    .interval_end(interval_end), .real_in(real_in), .reactive_in(reactive_in), .apparent_in(apparent_in),
    .rms_volt_in(rms_volt_in), .rms_cur_in(rms_cur_in), .isq_sum_in(isq_sum_in),
    .isq_residue_in(isq_residue_in), .vsq_sum_in(vsq_sum_in), .load_angle_in(load_angle_in),
    .angle_a_to_c_in(angle_a_to_c_in), .angle_a_to_b_in(angle_a_to_b_in), .frequency_in(frequency_in),
    .temp_offset_in(temp_offset_in), .sample_valid(sample_valid), .cur_sample(cur_sample),
    .volt_sample(volt_sample), .peak_volt_in(peak_volt_in), .sag_alarm(sag_alarm));
  mrr_host_model host (.clock(clock), .reg_index(reg_index), .reg_rd(reg_rd), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));
  always #2 clock = ~clock;
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      miscompares++;
      print_verdict();
    end
  end
  task chk(input mrr_pkg::mrr_word_t got, input mrr_pkg::mrr_word_t exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED %0t word %h expected %h", $time, got, exp);
    end
  endtask
  task chk_bit(input logic got, input logic exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED %0t alarm %b expected %b", $time, got, exp);
    end
  endtask
  task pulse();
    interval_end <= 1'b1;
    @(posedge clock);
    interval_end <= 1'b0;
    @(posedge clock);
  endtask
  // bit k of the step number sets the sign of phase k's voltage
  task samp(input int k);
    volt_sample <= {k[2] ? 16'h8100 : 16'h0100, k[1] ? 16'h8100 : 16'h0100, k[0] ? 16'h8100 : 16'h0100};
    sample_valid <= 1'b1;
    @(posedge clock);
    sample_valid <= 1'b0;
    @(posedge clock);
  endtask
  task wait_alarm(input logic v);
    int n;
    n = 0;
    while (sag_alarm !== v && n < 12) begin
      @(negedge clock);
      n++;
    end
  endtask
  task print_verdict();
    $display("checks %0d miscompares %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    clock = 1'b0;
    rst_b = 1'b0;
    ce = 1'b1;
    {engine_only, interval_end, sample_valid, freq_select} = 5'h00;
    cur_sample = {16'h0101, 16'h0100, 16'h0100};
    volt_sample = '0;
    peak_volt_in = 16'hFFFF;
    for (int p = 0; p < 3; p++) begin
      real_in[p] = 32'h1100_0000 + p;
      reactive_in[p] = 32'h2200_0000 + p;
      apparent_in[p] = 32'h3300_0000 + p;
      isq_sum_in[p] = 32'h6600_0000 + p;
      vsq_sum_in[p] = 32'h7700_0000 + p;
      rms_volt_in[p] = 16'h4400 + 16'(p);
      rms_cur_in[p] = 16'h5500 + 16'(p);
      isq_residue_in[p] = 10'h155;
      load_angle_in[p] = 9'h1F0 + 9'(p);
    end
    {angle_a_to_b_in, angle_a_to_c_in, frequency_in, temp_offset_in} = 64'h0ABB_0ACC_0258_002C;
    repeat (3) @(posedge clock);
    rst_b <= 1'b1;
    @(posedge clock);
    host.rd(7'h2E, d); chk(d, 32'h0000_0050);
    host.rd(7'h1D, d); chk(d, 32'h0000_0000);
    host.rd(7'h12, d); chk(d, 32'h0000_0000);
    pulse();
    for (int p = 0; p < 3; p++) begin
      rows.push_back('{7'h00 + 7'(p), real_in[p]});
      rows.push_back('{7'h03 + 7'(p), reactive_in[p]});
      rows.push_back('{7'h06 + 7'(p), apparent_in[p]});
      rows.push_back('{7'h09 + 7'(p), {rms_volt_in[p], 16'h0000}});
      rows.push_back('{7'h0C + 7'(p), {rms_cur_in[p], 16'h0000}});
      rows.push_back('{7'h39 + 7'(p), isq_sum_in[p]});
      rows.push_back('{7'h3D + 7'(p), vsq_sum_in[p]});
      rows.push_back('{7'h4A + 7'(p), 32'h0000_0155});
    end
    rows.push_back('{7'h10, {angle_a_to_b_in, angle_a_to_c_in}});
    rows.push_back('{7'h11, {frequency_in, temp_offset_in}});
    rows.push_back('{7'h3C, 32'h0000_0000});
    rows.push_back('{7'h4D, 32'h0000_0000});
    foreach (rows[i]) begin
      host.rd(rows[i].idx, d); chk(d, rows[i].exp);
    end
    host.rd(7'h0F, d); chk(d & 32'h07FF_FFFF, {5'h00, load_angle_in[0], load_angle_in[1], load_angle_in[2]});
    host.rd_pair(7'h10, d, d2);
    chk(d, {angle_a_to_b_in, angle_a_to_c_in});
    chk(d2, {angle_a_to_b_in, angle_a_to_c_in});
    host.wr(7'h00, 32'h0BAD_0BAD);
    @(negedge clock); chk_bit(write_ignored, 1'b1);
    @(posedge clock);
    host.rd(7'h00, d); chk(d, 32'h1100_0000);
    engine_only <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      host.rd(7'h06 + 7'(3 * i), d); chk(d, 32'h0000_0000);
    end
    host.rd(7'h39, d); chk(d, 32'h6600_0000);
    engine_only <= 1'b0;
    for (int s = 0; s < 4; s++) begin
      freq_select <= 2'(s);
      samp(0);
      pulse();
      if (s == 0) isq_residue_in <= {3{10'h055}};
      for (int k = 1; k < 8; k++) samp(k);
      pulse();
      host.rd(7'h35, d); chk(d, zc[s]);
      if (s == 0) begin
        host.rd(7'h3C, d); chk(d, 32'h0000_0FCA);
        host.rd(7'h4D, d); chk(d, 32'h0000_0006);
        host.rd(7'h4A, d); chk(d, 32'hFFFF_FF00);
      end
    end
    host.wr(7'h1D, 32'h7FFF_FFFF);
    host.rd(7'h1D, d); chk(d, 32'h7FFF_FFFF);
    pulse();
    foreach (cz[i]) begin
      host.rd(cz[i], d); chk(d, 32'h0000_0000);
    end
    host.rd(7'h3D, d); chk(d, 32'h7700_0000);
    ce <= 1'b0;
    isq_residue_in <= {3{10'h155}};
    pulse();
    ce <= 1'b1;
    host.rd(7'h4A, d); chk(d, 32'h0000_0000);
    host.wr(7'h2E, 32'h000A_0002);
    host.rd(7'h2E, d); chk(d, 32'h000A_0002);
    peak_volt_in <= 16'h0005;
    repeat (4) @(posedge clock);
    @(negedge clock); chk_bit(sag_alarm, 1'b0);
    wait_alarm(1'b1); chk_bit(sag_alarm, 1'b1);
    @(posedge clock);
    peak_volt_in <= 16'h0014;
    wait_alarm(1'b0); chk_bit(sag_alarm, 1'b0);
    @(posedge clock);
    rst_b <= 1'b0;
    repeat (2) @(posedge clock);
    rst_b <= 1'b1;
    @(posedge clock);
    host.rd(7'h2E, d); chk(d, 32'h0000_0050);
    host.rd(7'h00, d); chk(d, 32'h0000_0000);
    print_verdict();
  end
endmodule // tb
`default_nettype wire
